/* File: hdl/bps_pkg.sv */
// Package for the primary status flag bank: offsets, bit positions, types
package bps_pkg;

   // Register map (byte addresses, 32-bit words)
   localparam logic [7:0] BPS_CMD_STAT_OFS = 8'h04;
   localparam logic [7:0] BPS_CAP_PTR_OFS  = 8'h34;
   localparam logic [7:0] BPS_CTRL_OFS     = 8'h40;

   // Command half bits
   localparam int BPS_CMD_PERR_EN   = 6;
   localparam int BPS_CMD_SERR_EN   = 8;
   localparam int BPS_CMD_INT_DIS   = 10;

   // Status half bits (positions within the 32-bit word)
   localparam int BPS_ST_INT_PEND   = 19;
   localparam int BPS_ST_CAP_LIST   = 20;
   localparam int BPS_ST_66MHZ      = 21;
   localparam int BPS_ST_FBB        = 23;
   localparam int BPS_ST_MDPE       = 24;
   localparam int BPS_ST_TSEL_LO    = 25;
   localparam int BPS_ST_STA        = 27;
   localparam int BPS_ST_RTA        = 28;
   localparam int BPS_ST_RMA        = 29;
   localparam int BPS_ST_SSE        = 30;
   localparam int BPS_ST_DPE        = 31;

   // Target select timing codes
   localparam logic [1:0] BPS_TSEL_FAST   = 2'h0;
   localparam logic [1:0] BPS_TSEL_MEDIUM = 2'h1;

   // Reset values
   localparam logic [15:0] BPS_CMD_RST     = 16'h0000;
   localparam logic [7:0]  BPS_CAP_PTR_RST = 8'h00;
   localparam logic [5:0]  BPS_ERR_RST     = 6'h00;

   // Writable command bits
   localparam logic [15:0] BPS_CMD_WMASK   = 16'h0547;

   // Event strobes from the primary interface logic
   typedef struct packed {
      logic poisoned_cpl_rx;   // forward: poisoned completion received
      logic poisoned_wr_tx;    // forward: outgoing write poisoned
      logic ca_cpl_tx;         // forward: completed with completer abort
      logic ca_cpl_rx;         // forward: completer-abort completion received
      logic ur_cpl_rx;         // forward: unsupported-request completion rx
      logic err_msg_tx;        // forward: fatal/non-fatal message sent
      logic poisoned_tlp_rx;   // forward: any poisoned TLP detected
      logic rd_data_perr;      // reverse: parity error on read data/split rsp
      logic wr_perr_seen;      // reverse: parity error pin seen on write
      logic split_msg_perr;    // reverse: split completion msg reports perr
      logic tgt_abort_sig;     // reverse: signaled target abort as target
      logic tgt_abort_det;     // reverse: target abort detected as master
      logic mst_abort_det;     // reverse: master abort detected as master
      logic serr_req;          // reverse: request to assert system error
      logic addr_data_perr;    // reverse: address/data parity error seen
   } bps_event_t;

   typedef struct packed {
      logic reverse;           // 1: reverse bridge, 0: forward bridge
      logic prim_pci_mode;     // 1: primary runs conventional PCI
   } bps_strap_t;

endpackage : bps_pkg

/* File: hdl/bps_flag.sv */
// One sticky write-one-to-clear status flag
`timescale 1ns/1ps
module bps_flag (
   input  wire logic clk,     // Configuration clock
   input  wire logic rst_b,   // Asynchronous reset, active low
   input  wire logic set,     // Event that sets the flag
   input  wire logic clr,     // Software writes one to this bit
   output logic      flag_q   // Flag state
);
   logic flag_d;

   always_comb begin
      // Set beats clear so a coincident event is not lost
      flag_d = set | (flag_q & ~clr); // see [R20]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule // bps_flag

/* File: hdl/bps_status.sv */
// Primary command/status word of the bridge configuration header
//
// Summary of operation
// [R01] Bit 19 shows pending legacy interrupt request
// [R02] Bit 20 always one; list pointer at 34h
// [R03] Bit 21 zero forward, one reverse
// [R04] Bit 23 one only reverse with PCI primary
// [R05] Forward: poisoned completion or poisoning sets 24
// [R06] Reverse: three parity events set bit 24
// [R07] Bit 24 setting gated by parity response enable
// [R08] Bits 26:25 read 00 forward, 01 reverse
// [R09] Forward: completer-abort completion sent sets 27
// [R10] Reverse: signaled target abort sets 27
// [R11] Forward: completer-abort completion received sets 28
// [R12] Reverse: detected target abort sets 28
// [R13] Forward: unsupported-request completion sets 29
// [R14] Reverse: detected master abort sets 29
// [R15] Forward: error message sent sets 30
// [R16] Reverse: system error output asserted sets 30
// [R17] System error output needs command bit 8
// [R18] Forward: poisoned packet detected sets 31
// [R19] Reverse: address/data parity error sets 31
// [R20] Error flags sticky, write one clears
// [R21] Reserved bits read zero, ignore writes
`timescale 1ns/1ps
module bps_status
   import bps_pkg::*;
(
   input  wire logic             clk,           // Configuration clock
   input  wire logic             rst_b,         // Async reset, active low
   input  wire logic [7:0]       reg_addr,      // Byte address
   input  wire logic [31:0]      reg_wdata,     // Write data
   input  wire logic             reg_wr,        // Write strobe
   input  wire logic             reg_rd,        // Read strobe
   output logic      [31:0]      reg_rdata,     // Read data, cycle after
   input  wire bps_pkg::bps_strap_t strap,      // Direction and mode straps
   input  wire bps_pkg::bps_event_t evt,        // One-cycle event strobes
   input  wire logic             intx_pending,  // Legacy request pending
   output logic                  perr_resp_en,  // Command bit 6
   output logic                  intx_disable,  // Command bit 10
   output logic                  system_error_out_n // Primary system error
);
   import bps_pkg::*;

   logic [15:0] cmd_q, cmd_d;
   logic [7:0]  cap_ptr_q, cap_ptr_d;
   logic [31:0] rdata_q, rdata_d;
   logic        serr_q, serr_d;
   logic        int_pend_q, int_pend_d;
   logic        rev, fwd;
   logic        wr_stat, wr_cap;
   logic [5:0]  err_set;
   logic [5:0]  err_clr;
   logic [5:0]  err_q;
   logic [31:0] stat_word;

   assign rev     = strap.reverse;
   assign fwd     = ~strap.reverse;
   assign wr_stat = reg_wr && (reg_addr == BPS_CMD_STAT_OFS);
   assign wr_cap  = reg_wr && (reg_addr == BPS_CAP_PTR_OFS);

   // Command half and capability pointer
   always_comb begin
      cmd_d     = cmd_q;
      cap_ptr_d = cap_ptr_q;
      if (wr_stat) begin
         cmd_d = reg_wdata[15:0] & BPS_CMD_WMASK;
      end
      if (wr_cap) begin
         cap_ptr_d = reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_q     <= BPS_CMD_RST;
         cap_ptr_q <= BPS_CAP_PTR_RST;
      end else begin
         cmd_q     <= cmd_d;
         cap_ptr_q <= cap_ptr_d;
      end
   end

   assign perr_resp_en = cmd_q[BPS_CMD_PERR_EN];
   assign intx_disable = cmd_q[BPS_CMD_INT_DIS];

   // Interrupt status follows the pending request; system error output
   always_comb begin
      int_pend_d = intx_pending; // see [R01]
      // Only driven in reverse mode and only with enable set
      serr_d = rev & evt.serr_req & cmd_q[BPS_CMD_SERR_EN]; // see [R17]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_pend_q <= 1'b0;
         serr_q     <= 1'b0;
      end else begin
         int_pend_q <= int_pend_d;
         serr_q     <= serr_d;
      end
   end

   assign system_error_out_n = ~serr_q;

   // Set conditions, index 0..5 = bits 24,27,28,29,30,31
   always_comb begin
      err_set[0] = cmd_q[BPS_CMD_PERR_EN] & // see [R07]
                   ((fwd & (evt.poisoned_cpl_rx |
                            evt.poisoned_wr_tx)) | // see [R05]
                    (rev & (evt.rd_data_perr | evt.wr_perr_seen |
                            evt.split_msg_perr))); // see [R06]
      err_set[1] = (fwd & evt.ca_cpl_tx) |   // see [R09]
                   (rev & evt.tgt_abort_sig); // see [R10]
      err_set[2] = (fwd & evt.ca_cpl_rx) |   // see [R11]
                   (rev & evt.tgt_abort_det); // see [R12]
      err_set[3] = (fwd & evt.ur_cpl_rx) |   // see [R13]
                   (rev & evt.mst_abort_det); // see [R14]
      // Flag follows the actual pin assertion, one cycle after request
      err_set[4] = (fwd & evt.err_msg_tx) |  // see [R15]
                   serr_q;                    // see [R16]
      err_set[5] = (fwd & evt.poisoned_tlp_rx) | // see [R18]
                   (rev & evt.addr_data_perr);   // see [R19]
      err_clr    = {6{wr_stat}} &
                   {reg_wdata[BPS_ST_DPE], reg_wdata[BPS_ST_SSE],
                    reg_wdata[BPS_ST_RMA], reg_wdata[BPS_ST_RTA],
                    reg_wdata[BPS_ST_STA], reg_wdata[BPS_ST_MDPE]}; // see [R20]
   end

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_flag
         bps_flag u_flag (
            .clk    (clk),
            .rst_b  (rst_b),
            .set    (err_set[g]),
            .clr    (err_clr[g]),
            .flag_q (err_q[g])
         );
      end
   endgenerate

   // Assemble the word; reserved bits stay zero
   always_comb begin
      stat_word = 32'h0000_0000; // see [R21]
      stat_word[15:0]             = cmd_q;
      stat_word[BPS_ST_INT_PEND]  = int_pend_q;      // see [R01]
      stat_word[BPS_ST_CAP_LIST]  = 1'b1;            // see [R02]
      stat_word[BPS_ST_66MHZ]     = rev;             // see [R03]
      stat_word[BPS_ST_FBB]       = rev & strap.prim_pci_mode; // see [R04]
      stat_word[BPS_ST_MDPE]      = err_q[0];
      stat_word[BPS_ST_TSEL_LO +: 2]   = rev ? BPS_TSEL_MEDIUM
                                             : BPS_TSEL_FAST; // see [R08]
      stat_word[BPS_ST_DPE -: 5]  = err_q[5:1];
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            BPS_CMD_STAT_OFS: rdata_d = stat_word;
            BPS_CAP_PTR_OFS:  rdata_d = {24'h00_0000, cap_ptr_q}; // see [R02]
            default:          rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
endmodule // bps_status

/* File: dv/bps_far_end.sv */
// Far-side model: primary link or bus raising event strobes
`timescale 1ns/1ps
module bps_far_end
   import bps_pkg::*;
(
   input  wire logic        clk, // Clock
   output bps_pkg::bps_event_t evt // One-cycle event strobes
);
   import bps_pkg::*;
   initial evt = '0;
   // One strobe per call, held one cycle
   // Also covers
   task automatic pulse(input int k);
      @(posedge clk);
      evt <= bps_event_t'(15'h4000 >> k);
      @(posedge clk);
      evt <= '0;
   endtask
endmodule // bps_far_end

/* File: dv/bps_status_checker.sv */
// Port checker for the primary status word
`timescale 1ns/1ps
module bps_status_checker
   import bps_pkg::*;
(
   input wire logic        clk,    // Clock
   input wire logic        rst_b,  // Reset, active low
   input wire logic [7:0]  reg_addr,  // Address
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic        reg_wr, // Write strobe
   input wire logic        reg_rd, // Read strobe
   input wire logic [31:0] reg_rdata, // Read data
   input wire bps_pkg::bps_strap_t strap, // Straps
   input wire bps_pkg::bps_event_t evt,   // Events
   input wire logic        intx_pending, // Pending request
   input wire logic        perr_resp_en, // Command bit 6
   input wire logic        intx_disable, // Command bit 10
   input wire logic        system_error_out_n // Error pin
);
   import bps_pkg::*;
   logic serr_en_q; // Shadow of command bit 8, seen only through writes
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic st_rd = reg_rd && reg_addr == BPS_CMD_STAT_OFS;
   wire logic cmd_wr = reg_wr && reg_addr == BPS_CMD_STAT_OFS;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         serr_en_q <= 1'h0;
      end else if (cmd_wr) begin
         serr_en_q <= reg_wdata[BPS_CMD_SERR_EN];
      end
   end
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   a_cmd_write: assert property (cmd_wr |=>
      perr_resp_en == $past(reg_wdata[6])
      && intx_disable == $past(reg_wdata[10]))
      else $error("command outputs wrong");
   a_fixed_bits: assert property (st_rd |=> reg_rdata[20]
      && reg_rdata[18:16] == 3'h0 && !reg_rdata[22])
      else $error("fixed status bits wrong");
   a_speed_bit: assert property (st_rd |=>
      reg_rdata[21] == $past(strap.reverse))
      else $error("speed bit wrong");
   a_fbb_bit: assert property (st_rd |=>
      reg_rdata[23] == ($past(strap.reverse) && $past(strap.prim_pci_mode)))
      else $error("fbb bit wrong");
   a_tsel_field: assert property (st_rd |=>
      reg_rdata[26:25] == ($past(strap.reverse) ? BPS_TSEL_MEDIUM
                                                : BPS_TSEL_FAST))
      else $error("select timing wrong");
   a_int_pend: assert property (st_rd && $stable(intx_pending) |=>
      reg_rdata[19] == $past(intx_pending)) else $error("pending bit wrong");
   a_serr_gate: assert property (!system_error_out_n |->
      $past(evt.serr_req) && $past(strap.reverse) && $past(serr_en_q))
      else $error("error pin without cause");
   a_serr_fire: assert property (evt.serr_req && strap.reverse
      && serr_en_q |=> !system_error_out_n)
      else $error("error pin missing");
endmodule // bps_status_checker
bind bps_status bps_status_checker u_chk (.clk(clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap(strap), .evt(evt),
   .intx_pending(intx_pending), .perr_resp_en(perr_resp_en),
   .intx_disable(intx_disable), .system_error_out_n(system_error_out_n));

/* File: dv/bps_status_tb.sv */
// Testbench for the primary status word
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end
module bps_status_tb;
   import bps_pkg::*;
   logic clk, rst_b, reg_wr, reg_rd, intx_pending;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, d, ex, er;
   logic [15:0] cmd;
   wire logic [31:0] reg_rdata;
   wire logic perr_resp_en, intx_disable, system_error_out_n;
   bps_strap_t strap;
   bps_event_t evt;
   int n_errors, compares;
   int tbl[15] = '{24, 24, 27, 28, 29, 30, 31,
                   24, 24, 24, 27, 28, 29, 30, 31};
   logic ep;
   bps_status dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .strap(strap), .evt(evt),
      .intx_pending(intx_pending), .perr_resp_en(perr_resp_en),
      .intx_disable(intx_disable), .system_error_out_n(system_error_out_n));
   bps_far_end far (.clk(clk), .evt(evt));
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic results;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      results;
   end
   initial begin
      {reg_wr, reg_rd, intx_pending} = '0; reg_addr = '0; reg_wdata = '0;
      strap = '0; n_errors = 0; compares = 0; rst_b = 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h04, d);
      `CHK("reset word", 32'h00100000, d)
      `CHK("pin idle", 1'b1, system_error_out_n)
      intx_pending <= 1'b1;
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04, d);
      `CHK("command mask", 32'h00180547, d)
      `CHK("intx disable", 1'b1, intx_disable)
      intx_pending <= 1'b0;
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08, d); `CHK("unmapped", 32'h0, d)
      wr(8'h34, 32'hFFFFFF5C);
      rd(8'h34, d);
      `CHK("cap pointer", 32'h0000005C, d)
      for (int p = 0; p < 2; p++) for (int m = 0; m < 2; m++)
         for (int k = 0; k < 15; k++) begin
            strap <= '{reverse: m[0], prim_pci_mode: p[0]};
            cmd = p ? 16'h0147 : 16'h0000;
            wr(8'h04, {16'hF900, cmd});
            #1 `CHK("perr enable", p[0], perr_resp_en)
            far.pulse(k);
            ep = !(m && p && k == 13);
            #1 `CHK("error pin", ep, system_error_out_n)
            er = ((m == (k >= 7)) && (p || tbl[k] != 24) && (p || k != 13))
               ? 32'h1 << tbl[k] : 32'h0;
            ex = {16'h0, cmd} | 32'h00100000 | (32'(m) << 21)
               | (32'(m & p) << 23) | er
               | (32'(m ? BPS_TSEL_MEDIUM : BPS_TSEL_FAST) << 25);
            rd(8'h04, d);
            `CHK("status word", ex, d)
            wr(8'h04, {16'h0, cmd});
            rd(8'h04, d);
            `CHK("sticky word", ex, d)
         end
      results;
   end
endmodule // bps_status_tb
